// file: logic/ssim_irq_mask.v
// Interrupt enable, disable and mask logic of a synchronous serial controller
// Summary of operation
// - Writing one to enable-set sets mask bit
// - Writing one to enable-clear clears mask bit
// - Mask view reads one per enabled source
// - Bits 0-7: transmit and receive sources
// - Bits 8-11: compares and frame syncs
// - Every source has independent enable bit
// - Compare and sync flags sticky until read
// - Holding-free flag high while holding register empty
//
// Design decisions made here: the register addresses and register access over APB.
`default_nettype none
`include "ssim_map.vh"
module ssim_irq_mask
(
  input wire clk,
  input wire rst_n,
  input wire clkEn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire txHoldingFull,
  input wire [`SSIM_NSRC-1:0] srcEvents,
  output reg irq
);

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  wire wrSet;
  wire wrClear;
  wire rdFlags;
  wire mapped;
  wire [11:0] stickyMask;
  wire [`SSIM_NSRC-1:0] evIn;
  wire [`SSIM_NSRC-1:0] flags;
  reg [`SSIM_NSRC-1:0] enable_q;
  reg [`SSIM_NSRC-1:0] enable_d;
  reg [31:0] rdata_d;
  reg inAccess_q;

  assign stickyMask = `SSIM_STICKY_MASK;

  ssim_apb_slave uDecode
  (
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .wrSet(wrSet),
    .wrClear(wrClear),
    .rdFlags(rdFlags),
    .mapped(mapped)
  );

  // ------------------------------------------------------------
  // Event flags
  // ------------------------------------------------------------
  // Holding-free level is the inverse of the holding-register-full input
  assign evIn = {srcEvents[`SSIM_NSRC-1:1], ~txHoldingFull};

  genvar gi;
  generate
    for (gi = 0; gi < `SSIM_NSRC; gi = gi + 1)
    begin : gFlag
      ssim_flag_bit uFlag
      (
        .clk(clk),
        .rst_n(rst_n),
        .clkEn(clkEn),
        .sticky(stickyMask[gi]),
        .srcEvent(evIn[gi]),
        .readClear(rdFlags && !inAccess_q),
        .flag_q(flags[gi])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // Mask register
  // ------------------------------------------------------------
  always @*
  begin
    enable_d = enable_q;
    if (wrSet && !inAccess_q)
      enable_d = enable_d | pwdata[`SSIM_NSRC-1:0]; // Each bit alone
    if (wrClear && !inAccess_q)
      enable_d = enable_d & ~pwdata[`SSIM_NSRC-1:0];
  end

  always @*
  begin
    rdata_d = 32'h00000000;
    if (paddr == `SSIM_OFF_ENABLE_VIEW)
      rdata_d = {20'h00000, enable_q};
    else if (paddr == `SSIM_OFF_FLAGS)
      rdata_d = {20'h00000, flags};
  end

  // ------------------------------------------------------------
  // Bus answer and interrupt
  // ------------------------------------------------------------
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      enable_q <= `SSIM_RST_ENABLES;
      inAccess_q <= 1'b0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      irq <= 1'b0;
    end
    else if (clkEn)
    begin
      enable_q <= enable_d;
      // One wait state: answer in the second access cycle
      if (psel && penable && !inAccess_q)
      begin
        inAccess_q <= 1'b1;
        pready <= 1'b1;
        pslverr <= !mapped;
        prdata <= pwrite ? 32'h00000000 : rdata_d;
      end
      else
      begin
        inAccess_q <= 1'b0;
        pready <= 1'b0;
        pslverr <= 1'b0;
      end
      irq <= |(flags & enable_q);
    end
  end

endmodule // ssim_irq_mask
`default_nettype wire

// file: include/ssim_map.vh
// Register map, field positions and reset values of the serial interrupt mask block
`ifndef SSIM_MAP_VH
`define SSIM_MAP_VH

`define SSIM_NSRC 12

// Byte offsets on the register bus
`define SSIM_OFF_ENABLE_SET 12'h000
`define SSIM_OFF_ENABLE_CLEAR 12'h004
`define SSIM_OFF_ENABLE_VIEW 12'h008
`define SSIM_OFF_FLAGS 12'h00c

// Source positions
`define SSIM_TX_HOLDING_FREE 0
`define SSIM_TX_ALL_SENT 1
`define SSIM_TX_TRANSFER_DONE 2
`define SSIM_TX_BUFFERS_EXHAUSTED 3
`define SSIM_RX_WORD_AVAILABLE 4
`define SSIM_RX_OVERWRITE_ERROR 5
`define SSIM_RX_TRANSFER_DONE 6
`define SSIM_RX_BUFFERS_FILLED 7
`define SSIM_COMPARE_ZERO_MATCH 8
`define SSIM_COMPARE_ONE_MATCH 9
`define SSIM_TX_FRAME_SYNC_SEEN 10
`define SSIM_RX_FRAME_SYNC_SEEN 11

// Sticky sources: the two compares and the two syncs
`define SSIM_STICKY_MASK 12'hf00

// Reset values
`define SSIM_RST_ENABLES 12'h000
`define SSIM_RST_FLAGS 12'h000

`endif

// file: logic/ssim_flag_bit.v
// One event flag: level follows the source, or sticky until the flags are read
`default_nettype none
module ssim_flag_bit
(
  input wire clk,
  input wire rst_n,
  input wire clkEn,
  input wire sticky,
  input wire srcEvent,
  input wire readClear,
  output reg flag_q
);

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      flag_q <= 1'b0;
    else if (clkEn)
    begin
      if (!sticky)
        flag_q <= srcEvent;
      else if (srcEvent)
        flag_q <= 1'b1; // Set wins over the read clear
      else if (readClear)
        flag_q <= 1'b0;
    end
  end

endmodule // ssim_flag_bit
`default_nettype wire

// file: logic/ssim_apb_slave.v
// APB slave decode: access strobes (one wait state added in ssim_irq_mask), error on unmapped offsets
`default_nettype none
`include "ssim_map.vh"
module ssim_apb_slave
(
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  output wire wrSet,
  output wire wrClear,
  output wire rdFlags,
  output wire mapped
);

  wire access;

  assign access = psel && penable;
  assign mapped = (paddr == `SSIM_OFF_ENABLE_SET) || (paddr == `SSIM_OFF_ENABLE_CLEAR) ||
    (paddr == `SSIM_OFF_ENABLE_VIEW) || (paddr == `SSIM_OFF_FLAGS);
  assign wrSet = access && pwrite && (paddr == `SSIM_OFF_ENABLE_SET);
  assign wrClear = access && pwrite && (paddr == `SSIM_OFF_ENABLE_CLEAR);
  assign rdFlags = access && !pwrite && (paddr == `SSIM_OFF_FLAGS);

endmodule // ssim_apb_slave
`default_nettype wire

// file: bench/ssim_irq_mask_props.sv
// Serial mask checker
`default_nettype none
module ssim_irq_mask_chk (
  input wire logic clk, rst_n, psel, penable, pwrite, pready, pslverr, txHoldingFull, irq,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata, prdata
);
  timeunit 1ns / 1ps;
  wire logic take = psel && penable && !pready, rd = pready && !pwrite;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_TAKE: assert property (take |=> pready) else $error("late");
  AST_PULSE: assert property (pready |=> !pready) else $error("long");
  AST_HI: assert property (pready |-> prdata < 32'h1000) else $error("high");
  AST_ERR: assert property (pready && paddr > 12'h00c |-> pslverr) else $error("err");
  AST_ERRD: assert property (pslverr |-> prdata == 0) else $error("errd");
  AST_WO: assert property (rd && paddr < 12'h008 |-> prdata == 0) else $error("wo");
  AST_FREE: assert property (rd && paddr == 12'h00c |-> prdata[0] != $past(txHoldingFull, 2)) else $error("free");
  AST_CLR: assert property (take && pwrite && paddr == 12'h004 && pwdata[11:0] == 12'hfff
    |-> ##2 !irq) else $error("clr");
  cover property (pslverr);
  cover property (irq);
  cover property (rd);
endmodule // ssim_irq_mask_chk
bind ssim_irq_mask ssim_irq_mask_chk chk_u (.*);
`default_nettype wire

// file: bench/ssim_irq_mask_test.sv
// Serial mask bench
`default_nettype none
module ssim_irq_mask_test;
  timeunit 1ns / 1ps;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, txHoldingFull = 1, pready, pslverr, irq;
  logic [11:0] paddr = 0, srcEvents = 0, m = 0;
  logic [31:0] pwdata = 0, prdata, q[$];
  int miscompares, tests_run, cyc;
  ssim_irq_mask dut_u (.clkEn(1'b1), .*);
  task check(input [31:0] s, e);
    tests_run++;
    miscompares += int'(s !== e);
    if (s !== e) $display("[FAIL] %0t %h %h", $time, s, e);
  endtask
  task finish_test(input h);
    miscompares += h;
    $display("%0d %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task bus(input w, input [11:0] a, input [31:0] d);
    if (!w) q.push_back(d);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk) penable <= 1;
    do @(posedge clk); while (pready !== 1);
    {psel, penable} <= 0;
    @(posedge clk);
  endtask
  task ev(input int b);
    srcEvents[b] <= 1;
    @(posedge clk) srcEvents[b] <= 0;
    repeat (3) @(posedge clk);
  endtask
  always @(posedge clk)
  begin
    if (pready === 1 && !pwrite) check(prdata, q.pop_front());
    if (pready === 1) check({31'h0, pslverr}, {31'h0, paddr > 12'h00c});
    if (++cyc > 3000) finish_test(1);
  end
  initial forever #2 clk = ~clk;
  initial
  begin
    void'($urandom(2968));
    repeat (4) @(posedge clk);
    rst_n <= 1;
    for (int i = 0; i < 9; i++)
    begin
      bus(1, {9'h0, i[0], 2'h0}, $urandom);
      m = i[0] ? m & ~pwdata[11:0] : m | pwdata[11:0];
      bus(0, 12'h008, {20'h0, m});
    end
    bus(0, 12'h004, 0);
    bus(0, 12'h010, 0);
    $display("test 1 done");
    bus(1, 12'h000, 32'h100);
    ev(8);
    check({31'h0, irq}, 1);
    bus(0, 12'h00c, 32'h100);
    bus(1, 12'h004, 32'hfff);
    ev(9);
    check({31'h0, irq}, 0);
    txHoldingFull <= 0;
    bus(0, 12'h00c, 32'h201);
    $display("test 2 done");
    finish_test(0);
  end
endmodule // ssim_irq_mask_test
`default_nettype wire
